// ===== design/fddi_tx_cfg.svh
`ifndef FDDI_TX_CFG_SVH
`define FDDI_TX_CFG_SVH

// ****************************************************************
// framing and counts
// ****************************************************************
`define TX_BYTE_BITS    4'h0a
`define TX_BIT_CNT_MAX  4'h9
`define SM_TARGET_IDLE  4'h7
`define SM_CNT_MAX      4'hf
`define PAR_FLAG_RST    1'b0
`define LINE_LEVEL_RST  1'b0

// ****************************************************************
// 5-bit line codes, data symbols
// ****************************************************************
`define C5_D0 5'h1e
`define C5_D1 5'h09
`define C5_D2 5'h14
`define C5_D3 5'h15
`define C5_D4 5'h0a
`define C5_D5 5'h0b
`define C5_D6 5'h0e
`define C5_D7 5'h0f
`define C5_D8 5'h12
`define C5_D9 5'h13
`define C5_DA 5'h16
`define C5_DB 5'h17
`define C5_DC 5'h1a
`define C5_DD 5'h1b
`define C5_DE 5'h1c
`define C5_DF 5'h1d

// ****************************************************************
// 5-bit line codes, control symbols
// ****************************************************************
`define C5_J  5'h18
`define C5_K  5'h11
`define C5_T  5'h0d
`define C5_R  5'h07
`define C5_S  5'h19
`define C5_I  5'h1f
`define C5_H  5'h04
`define C5_Q  5'h00

`endif

// ===== design/fddi_tx_pkg.sv
`default_nettype none

package fddi_tx_pkg;

    // ************************************************************
    // words and symbol pairs
    // ************************************************************
    typedef struct packed {
        logic       parity;
        logic       ctrl;
        logic [3:0] sym_hi;
        logic [3:0] sym_lo;
    } tx_word_t;

    typedef struct packed {
        logic       ctrl;
        logic [3:0] hi;
        logic [3:0] lo;
    } sym_pair_t;

    // ************************************************************
    // enumerations
    // ************************************************************
    // control symbol nibble codes carried when ctrl is set
    typedef enum logic [3:0] {CS_J, CS_K, CS_T, CS_R, CS_S, CS_I, CS_H, CS_Q} ctrl_sym_t;
    typedef enum logic [2:0] {TM_FORWARD, TM_IDLE, TM_MASTER, TM_HALT, TM_QUIET} tx_mode_t;
    typedef enum logic [1:0] {IC_NONE, IC_ONE_SHOT, IC_PERIODIC, IC_CONTINUOUS} inj_mode_t;
    typedef enum logic [1:0] {RF_REPEAT, RF_HALT, RF_IDLE, RF_END} rf_state_t;
    typedef enum logic [1:0] {SM_FRAME, SM_PREAMBLE, SM_EXTEND} sm_state_t;

endpackage

`default_nettype wire

// ===== design/fddi_phy_transmit_path.sv
`include "fddi_tx_cfg.svh"
`default_nettype none

module fddi_phy_transmit_path #(
    parameter int FIFO_DEPTH = 2,
    parameter int CNT_W      = 8
) (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire fddi_tx_pkg::tx_word_t in_word,
    input  wire logic                 in_valid,
    output logic                      in_ready,
    input  wire logic [2:0]           transmit_mode_field,
    input  wire logic [1:0]           injection_control_field,
    input  wire logic                 tx_parity_check_enable,
    input  wire logic                 plain_nrz_select,
    input  wire logic [4:0]           injection_symbol_a,
    input  wire logic [4:0]           injection_symbol_b,
    input  wire logic [CNT_W-1:0]     injection_threshold,
    input  wire logic                 internal_loopback,
    input  wire logic                 external_loopback,
    input  wire logic                 parity_error_clear,
    output logic                      tx_parity_error_flag,
    output logic                      pmd_tx_data,
    output logic                      loop_rx_data,
    output logic                      clock_recovery_data
);
    import fddi_tx_pkg::*;

    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

    // ************************************************************
    // two-entry buffer ahead of the byte slots
    // ************************************************************
    tx_word_t        mem [FIFO_DEPTH];
    logic [PW-1:0]   wr_ptr;
    logic [PW-1:0]   rd_ptr;
    logic [PW:0]     count;
    logic            push;
    logic            pop;
    logic            head_valid;
    tx_word_t        head;

    // ready drops when full, so a stalled slot pushes back on the source
    assign in_ready   = (count != (PW+1)'(FIFO_DEPTH));
    assign head_valid = (count != '0);
    assign push       = in_valid & in_ready;
    assign head       = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_word;
        end
    end

    // pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(FIFO_DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(FIFO_DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // ************************************************************
    // byte slot divider, one slot per ten bit cycles
    // ************************************************************
    logic [3:0] bit_cnt;
    logic       byte_en;

    assign byte_en = (bit_cnt == `TX_BIT_CNT_MAX);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bit_cnt <= '0;
        end else begin
            bit_cnt <= byte_en ? '0 : bit_cnt + 1'b1;
        end
    end

    // ************************************************************
    // slot source, parity and symbol classification
    // ************************************************************
    rf_state_t  rf_state;
    rf_state_t  next_rf;
    sm_state_t  sm_state;
    sm_state_t  next_sm;
    logic [3:0] sm_cnt;
    logic       sm_deleted;
    logic       head_jk;
    logic       head_ix;
    logic       extend_now;
    logic       del_now;
    logic       take;
    tx_word_t   src;
    logic       src_perr;
    logic       src_jk;
    logic       src_ix;
    logic       src_t;
    logic       src_bad;
    logic       rs_early;
    logic       rf_viol;

    function automatic logic is_rs(input logic [3:0] s);
        is_rs = (s == CS_R) | (s == CS_S);
    endfunction

    assign head_jk = head.ctrl & (head.sym_hi == CS_J) & (head.sym_lo == CS_K);
    assign head_ix = head.ctrl & (head.sym_hi == CS_I);

    // a short preamble holds the JK back one slot and sends idle instead
    assign extend_now = byte_en & head_valid & head_jk & (sm_state == SM_PREAMBLE)
                      & (sm_cnt < `SM_TARGET_IDLE);
    // one surplus idle pair per long preamble is dropped between slots
    assign del_now    = !byte_en & head_valid & head_ix & (sm_state == SM_PREAMBLE)
                      & (sm_cnt > `SM_TARGET_IDLE) & !sm_deleted;
    assign take       = head_valid & !extend_now;
    assign pop        = (byte_en & take) | del_now;

    // an empty buffer or an extension slot feeds an idle pair
    assign src      = take ? head : tx_word_t'{1'b0, 1'b1, CS_I, CS_I};
    assign src_perr = take & tx_parity_check_enable & ~(^head);
    assign src_jk   = src.ctrl & (src.sym_hi == CS_J) & (src.sym_lo == CS_K);
    assign src_ix   = src.ctrl & (src.sym_hi == CS_I);
    assign src_t    = src.ctrl & ((src.sym_hi == CS_T) | (src.sym_lo == CS_T));
    assign src_bad  = src.ctrl & ((src.sym_hi > CS_Q) | (src.sym_lo > CS_Q));
    // R or S ahead of any T; a T followed by R or S passes
    assign rs_early = src.ctrl & (is_rs(src.sym_hi)
                    | (is_rs(src.sym_lo) & (src.sym_hi != CS_T)));
    assign rf_viol  = src_perr | src_bad;

    // ************************************************************
    // repeat filter
    // ************************************************************
    always_comb begin
        next_rf = rf_state;
        case (rf_state)
            RF_REPEAT: begin
                if (rf_viol | rs_early) begin
                    next_rf = RF_HALT;
                end else if (src_t) begin
                    next_rf = RF_END;
                end
            end
            RF_END: begin
                if (rf_viol) begin
                    next_rf = RF_HALT;
                end
            end
            RF_HALT: begin
                next_rf = RF_IDLE;
            end
            RF_IDLE: begin
                next_rf = RF_IDLE;
            end
            default: begin
                next_rf = RF_IDLE;
            end
        endcase
        if (src_ix) begin
            next_rf = RF_IDLE;
        end
        if (src_jk & !src_perr) begin
            next_rf = RF_REPEAT;
        end
    end

    sym_pair_t rf_out;
    logic      rf_halt_out;

    // first halt pair replaces the violating pair, the second fills the halt slot
    assign rf_halt_out = (next_rf == RF_HALT)
                       | ((rf_state == RF_HALT) & !src_jk & !src_ix);

    always_comb begin
        if (rf_halt_out) begin
            rf_out = '{ctrl: 1'b1, hi: CS_H, lo: CS_H};
        end else if (next_rf == RF_IDLE) begin
            rf_out = '{ctrl: 1'b1, hi: CS_I, lo: CS_I};
        end else begin
            rf_out = '{ctrl: src.ctrl, hi: src.sym_hi, lo: src.sym_lo};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rf_state <= RF_IDLE;
        end else if (byte_en) begin
            rf_state <= next_rf;
        end
    end

    // ************************************************************
    // smoother
    // ************************************************************
    logic out_idle;

    assign out_idle = rf_out.ctrl & (rf_out.hi == CS_I);

    always_comb begin
        next_sm = sm_state;
        case (sm_state)
            SM_FRAME: begin
                if (out_idle) begin
                    next_sm = SM_PREAMBLE;
                end
            end
            SM_PREAMBLE: begin
                if (extend_now) begin
                    next_sm = SM_EXTEND;
                end else if (src_jk) begin
                    next_sm = SM_FRAME;
                end
            end
            SM_EXTEND: begin
                next_sm = src_jk ? SM_FRAME : SM_PREAMBLE;
            end
            default: begin
                next_sm = SM_FRAME;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sm_state   <= SM_FRAME;
            sm_cnt     <= '0;
            sm_deleted <= 1'b0;
        end else begin
            if (del_now) begin
                sm_deleted <= 1'b1;
            end
            if (byte_en) begin
                sm_state <= next_sm;
                if (next_sm == SM_FRAME) begin
                    sm_cnt     <= '0;
                    sm_deleted <= 1'b0;
                end else if (out_idle & (sm_cnt != `SM_CNT_MAX)) begin
                    sm_cnt <= sm_cnt + 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // line state generator
    // ************************************************************
    sym_pair_t lsg_out;

    always_comb begin
        case (transmit_mode_field)
            TM_IDLE:   lsg_out = '{ctrl: 1'b1, hi: CS_I, lo: CS_I};
            TM_MASTER: lsg_out = '{ctrl: 1'b1, hi: CS_H, lo: CS_Q};
            TM_HALT:   lsg_out = '{ctrl: 1'b1, hi: CS_H, lo: CS_H};
            TM_QUIET:  lsg_out = '{ctrl: 1'b1, hi: CS_Q, lo: CS_Q};
            default:   lsg_out = rf_out;
        endcase
    end

    // ************************************************************
    // injection control
    // ************************************************************
    logic [CNT_W-1:0] inj_cnt;
    logic             inj_done;
    logic             inj_data;
    logic             inj_hit;
    logic             inject_now;

    assign inj_data = !lsg_out.ctrl;
    assign inj_hit  = (inj_cnt == injection_threshold);

    always_comb begin
        case (injection_control_field)
            IC_ONE_SHOT:   inject_now = inj_data & inj_hit & !inj_done;
            IC_PERIODIC:   inject_now = inj_data & (inj_cnt >= injection_threshold);
            IC_CONTINUOUS: inject_now = inj_data;
            default:       inject_now = 1'b0;
        endcase
    end

    // the counter restarts at each JK and after each periodic hit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            inj_cnt  <= '0;
            inj_done <= 1'b0;
        end else if (byte_en) begin
            if (src_jk) begin
                inj_cnt  <= '0;
                inj_done <= 1'b0;
            end else if (inj_data) begin
                if (inject_now & (injection_control_field == IC_PERIODIC)) begin
                    inj_cnt <= '0;
                end else if (inj_cnt != '1) begin
                    inj_cnt <= inj_cnt + 1'b1;
                end
                if (inject_now) begin
                    inj_done <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // 4B/5B encoder and output priority
    // ************************************************************
    function automatic logic [4:0] enc5(input logic c, input logic [3:0] s);
        if (c) begin
            case (s)
                CS_J:    enc5 = `C5_J;
                CS_K:    enc5 = `C5_K;
                CS_T:    enc5 = `C5_T;
                CS_R:    enc5 = `C5_R;
                CS_S:    enc5 = `C5_S;
                CS_I:    enc5 = `C5_I;
                CS_H:    enc5 = `C5_H;
                default: enc5 = `C5_Q;
            endcase
        end else begin
            case (s)
                4'h0:    enc5 = `C5_D0;
                4'h1:    enc5 = `C5_D1;
                4'h2:    enc5 = `C5_D2;
                4'h3:    enc5 = `C5_D3;
                4'h4:    enc5 = `C5_D4;
                4'h5:    enc5 = `C5_D5;
                4'h6:    enc5 = `C5_D6;
                4'h7:    enc5 = `C5_D7;
                4'h8:    enc5 = `C5_D8;
                4'h9:    enc5 = `C5_D9;
                4'ha:    enc5 = `C5_DA;
                4'hb:    enc5 = `C5_DB;
                4'hc:    enc5 = `C5_DC;
                4'hd:    enc5 = `C5_DD;
                4'he:    enc5 = `C5_DE;
                default: enc5 = `C5_DF;
            endcase
        end
    endfunction

    logic [9:0] lsg_code;
    logic [9:0] slot_code;

    assign lsg_code  = {enc5(lsg_out.ctrl, lsg_out.hi), enc5(lsg_out.ctrl, lsg_out.lo)};
    assign slot_code = inject_now ? {injection_symbol_a, injection_symbol_b}
                                  : lsg_code;

    // ************************************************************
    // shift register, line coding and routing
    // ************************************************************
    logic [9:0] shreg;
    logic       line_level;
    logic       next_level;

    // loaded once per slot, msb leaves first
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shreg <= {`C5_I, `C5_I};
        end else begin
            shreg <= byte_en ? slot_code : {shreg[8:0], 1'b0};
        end
    end

    assign next_level = plain_nrz_select ? shreg[9]
                                         : (line_level ^ shreg[9]);

    // all three outputs are registered; idle ports hold low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            line_level          <= `LINE_LEVEL_RST;
            pmd_tx_data         <= 1'b0;
            loop_rx_data        <= 1'b0;
            clock_recovery_data <= 1'b0;
        end else begin
            line_level          <= next_level;
            loop_rx_data        <= internal_loopback & next_level;
            clock_recovery_data <= !internal_loopback & external_loopback & next_level;
            pmd_tx_data         <= !internal_loopback & !external_loopback & next_level;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_parity_error_flag <= `PAR_FLAG_RST;
        end else begin
            tx_parity_error_flag <= (byte_en & src_perr)
                                  | (tx_parity_error_flag & !parity_error_clear);
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_PARITY_FLAG:
        assert property (byte_en & src_perr |=> tx_parity_error_flag
                         ##1 (tx_parity_error_flag | $past(parity_error_clear)))
        else $error("parity error did not set the sticky flag");

    AST_HALT_TO_IDLE:
        assert property (byte_en & (rf_state == RF_HALT) & !src_jk & !src_ix
                         |=> rf_state == RF_IDLE)
        else $error("filter did not reach idle after the second halt pair");

    AST_VIOL_HALT:
        assert property (byte_en & (rf_state == RF_REPEAT) & src_perr & !src_jk & !src_ix
                         |=> rf_state == RF_HALT ##0 $past(rf_halt_out))
        else $error("violation in repeat did not give halt");

    AST_JK_REPEAT:
        assert property (byte_en & src_jk & !src_perr |=> rf_state == RF_REPEAT)
        else $error("JK did not return filter to repeat");

    AST_IX_IDLE:
        assert property (byte_en & src_ix & !src_jk |=> rf_state == RF_IDLE)
        else $error("Ix did not put filter in idle");

    AST_SLOT_PERIOD:
        assert property (byte_en |=> (!byte_en) [*8] ##1 !byte_en ##1 byte_en)
        else $error("byte slot spacing is not ten cycles");

    AST_INJECT_LOAD:
        assert property (byte_en & inject_now
                         |=> shreg == {$past(injection_symbol_a), $past(injection_symbol_b)})
        else $error("injected pair not loaded into shift register");

    AST_CONT_INJECT:
        assert property (byte_en & (injection_control_field == IC_CONTINUOUS)
                         & !lsg_out.ctrl |-> inject_now)
        else $error("continuous mode skipped a data pair");

    AST_NRZI:
        assert property (!plain_nrz_select & !internal_loopback & !external_loopback
                         |=> pmd_tx_data == ($past(line_level) ^ $past(shreg[9])))
        else $error("NRZI level wrong on PMD output");

    AST_LOOP_QUIET:
        assert property (internal_loopback |=> !pmd_tx_data & !clock_recovery_data)
        else $error("loopback data leaked to another output");

endmodule

`default_nettype wire

// ===== tb/pmd_rx_model.sv
`default_nettype none

// ****************************************************************
// pmd side receiver: undoes line coding, keeps the last 20 bits
// ****************************************************************
module pmd_rx_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        line,
    input  wire logic        plain_nrz,
    output logic      [19:0] window
);
    timeunit 1ns;
    timeprecision 1ns;
    logic prev;

    // under nrzi a one is a change of level, so the last level is kept
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev   <= 1'b0;
            window <= 20'h0;
        end else begin
            prev   <= line;
            window <= {window[18:0], plain_nrz ? line : line ^ prev};
        end
    end
endmodule

`default_nettype wire

// ===== tb/tb_top.sv
`include "fddi_tx_cfg.svh"
`default_nettype none

// ****************************************************************
// transmit path bench
// ****************************************************************
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import fddi_tx_pkg::*;
    logic        clk, in_ready, par_flag, pmd, loop_rx, clk_rec;
    logic        nrst = 1'b0, in_valid = 1'b0, par_en = 1'b1, nrz = 1'b0, par_clr = 1'b0;
    logic        lb_int = 1'b0, lb_ext = 1'b0;
    tx_word_t    in_word = '0;
    logic [2:0]  tm = 3'h0;
    logic [1:0]  ic = 2'h0;
    logic [4:0]  isa = 5'h0, isb = 5'h0;
    logic [7:0]  thr = 8'h0;
    logic [19:0] win;
    logic [31:0] rs = 32'h7;
    logic [4:0]  dtab [16] = '{`C5_D0, `C5_D1, `C5_D2, `C5_D3, `C5_D4, `C5_D5, `C5_D6, `C5_D7,
                               `C5_D8, `C5_D9, `C5_DA, `C5_DB, `C5_DC, `C5_DD, `C5_DE, `C5_DF};
    tx_mode_t    tm_list [4] = '{TM_MASTER, TM_HALT, TM_QUIET, TM_IDLE};
    logic [19:0] pats [4] = '{{`C5_H, `C5_Q, `C5_H, `C5_Q}, {4{`C5_H}}, 20'h0, {4{`C5_I}}};
    int          bad_count = 0, check_count = 0;

    fddi_phy_transmit_path u_fddi_phy_transmit_path (.clk(clk), .nrst(nrst), .in_word(in_word),
        .in_valid(in_valid), .in_ready(in_ready), .transmit_mode_field(tm),
        .injection_control_field(ic), .tx_parity_check_enable(par_en),
        .plain_nrz_select(nrz), .injection_symbol_a(isa), .injection_symbol_b(isb),
        .injection_threshold(thr), .internal_loopback(lb_int), .external_loopback(lb_ext),
        .parity_error_clear(par_clr), .tx_parity_error_flag(par_flag), .pmd_tx_data(pmd),
        .loop_rx_data(loop_rx), .clock_recovery_data(clk_rec));
    pmd_rx_model u_pmd_rx_model (.clk(clk), .nrst(nrst), .line(pmd), .plain_nrz(nrz),
        .window(win));

    // xorshift source, fixed start so every run is the same
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    // odd parity over all ten bits; good low flips it on purpose
    function automatic tx_word_t mkw(logic c, logic [3:0] h, logic [3:0] l, logic good);
        return '{parity: ~^{c, h, l} ^ ~good, ctrl: c, sym_hi: h, sym_lo: l};
    endfunction

    task automatic check(string what, logic [19:0] seen, logic [19:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // word is held until the edge that sees ready high
    task automatic send(tx_word_t w);
        @(posedge clk);
        in_word  <= w;
        in_valid <= 1'b1;
        @(negedge clk);
        while (in_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        in_valid <= 1'b0;
    endtask

    // slot phase is not known here, so the line window is searched
    task automatic seek(string what, logic [19:0] exp);
        int n = 0;
        while (win !== exp && n < 300) begin
            @(negedge clk);
            n++;
        end
        check(what, win, exp);
    endtask

    task automatic print_verdict();
        if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // hang guard: the sequence needs a few thousand cycles, 20k is ample
    initial begin
        #400000;
        bad_count++;
        print_verdict();
    end

    initial begin
        logic [7:0] d;
        int         tog, ones;
        logic       b;
        repeat (8) @(posedge clk);
        check("reset outputs", {in_ready, pmd, loop_rx, clk_rec, par_flag}, 20'h10);
        nrst <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            d = (i == 0) ? 8'h0f : 8'(xs());
            send(mkw(1'b1, CS_J, CS_K, 1'b1));
            send(mkw(1'b0, d[7:4], d[3:0], 1'b1));
            seek("data pair", {`C5_J, `C5_K, dtab[d[7:4]], dtab[d[3:0]]});
        end
        send(mkw(1'b1, CS_J, CS_K, 1'b1));
        send(mkw(1'b0, 4'h3, 4'h5, 1'b0));
        // a following non-idle pair keeps an idle from cutting the second halt pair
        send(mkw(1'b0, 4'h3, 4'h5, 1'b1));
        seek("halt on bad parity", {4{`C5_H}});
        check("parity flag set", 20'(par_flag), 20'h1);
        @(posedge clk);
        par_clr <= 1'b1;
        par_en  <= 1'b0;
        @(posedge clk);
        par_clr <= 1'b0;
        send(mkw(1'b1, CS_J, CS_K, 1'b1));
        send(mkw(1'b0, 4'h3, 4'h5, 1'b0));
        seek("unchecked parity", {`C5_J, `C5_K, `C5_D3, `C5_D5});
        check("parity flag clear", 20'(par_flag), 20'h0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            tm <= tm_list[i];
            seek("line state", pats[i]);
        end
        // threshold zero makes every injecting mode hit the first data pair
        for (int m = 1; m < 4; m++) begin
            @(posedge clk);
            tm  <= TM_FORWARD;
            ic  <= 2'(m);
            isa <= 5'(xs());
            isb <= 5'(xs());
            send(mkw(1'b1, CS_J, CS_K, 1'b1));
            send(mkw(1'b0, 4'h9, 4'h1, 1'b1));
            seek("injected pair", {`C5_J, `C5_K, isa, isb});
        end
        // idle line: nrzi toggles every bit, nrz stays high
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            ic     <= IC_NONE;
            lb_int <= (k == 0);
            lb_ext <= (k == 1);
            nrz    <= (k == 2);
            repeat (25) @(negedge clk);
            tog  = 0;
            ones = 0;
            repeat (20) begin
                b = (k == 0) ? loop_rx : (k == 1) ? clk_rec : pmd;
                @(negedge clk);
                tog  += (((k == 0) ? loop_rx : (k == 1) ? clk_rec : pmd) !== b);
                ones += (pmd === 1'b1);
            end
            check("route toggles", 20'(tog), (k == 2) ? 20'd0 : 20'd20);
            check("pmd ones", 20'(ones), (k == 2) ? 20'd20 : 20'd0);
        end
        print_verdict();
    end
endmodule

`default_nettype wire
